// *** flash_reg_pkg.sv ***
// Constants for the flash controller register bank
// Assumes a byte-addressed register port on the bus clock
// Notes on behaviour
// - Accept 8, 16 and 32 bit accesses
// - Divider reads fully; loaded flag never writable
// - Lock bit set once, blocks divider writes
// - Debug mode writes low seven bits freely
// - Loaded flag rises on first divider write
// - Only reset or a debug-mode divider write clears the lock bit
// - Divider field makes roughly 1 MHz tick
// - Security register read-only, loaded on first clock after reset
// - Key enable only for value 10
// - Security field unsecured only for 10
// - Backdoor unlock forces security field to 10
// - Index selects command object word
// - Reserved index and configuration bits read zero
// - Enable bit gates complete flag onto interrupt
// - Status resets 80h, others 00h
// - Writing 1 to complete flag launches command
// - Access error is write-one-clear, blocks launch
package flash_reg_pkg;
   localparam logic [15:0] ADDR_CLOCK_DIVIDER = 16'h3020;
   localparam logic [15:0] ADDR_SECURITY = 16'h3021;
   localparam logic [15:0] ADDR_COMMAND_INDEX = 16'h3022;
   localparam logic [15:0] ADDR_CONFIGURATION = 16'h3024;
   localparam logic [15:0] ADDR_STATUS = 16'h3026;
   localparam logic [15:0] ADDR_PROTECTION = 16'h3028;
   localparam logic [15:0] ADDR_COMMAND_HIGH = 16'h302A;
   localparam logic [15:0] ADDR_COMMAND_LOW = 16'h302B;
   localparam logic [15:0] ADDR_OPTION = 16'h302C;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam int DIVIDER_LOADED_BIT = 7;
   localparam int DIVIDER_LOCK_BIT = 6;
   localparam int IRQ_ENABLE_BIT = 7;
   localparam int COMPLETE_BIT = 7;
   localparam int ACCESS_ERROR_BIT = 5;
   localparam int PROTECTION_ERROR_BIT = 4;
   localparam logic [1:0] KEY_ENABLED_CODE = 2'h2;
   localparam logic [1:0] UNSECURED_CODE = 2'h2;
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic [7:0] REGISTER_RESET = 8'h00;
   localparam int TIME_BASE_HZ = 1000000;
endpackage

// *** flash_reg_bank.sv ***
// Register bank of the flash controller: divider, security, index, config, status
// Assumes the sequencer and debug logic run on the same bus clock
`timescale 1ns/1ps
module flash_reg_bank (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [15:0] address,
   input wire logic [1:0] access_size,
   input wire logic [31:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [31:0] read_data,
   input wire logic background_debug_mode,
   input wire logic [7:0] security_byte,
   input wire logic backdoor_unsecure,
   input wire logic command_done,
   input wire logic set_access_error,
   input wire logic set_protection_violation,
   input wire logic [1:0] memory_status,
   input wire logic [2:0] sequencer_index,
   output logic [15:0] sequencer_word,
   output logic command_launch,
   output logic command_complete_irq,
   output logic time_base_tick,
   output logic [5:0] divider_value_field,
   output logic backdoor_key_enabled,
   output logic part_secured
);
   import flash_reg_pkg::*;

   typedef struct packed {
      logic [5:0] divider;
      logic lock;
      logic loaded;
      logic [5:0] tick_count;
      logic tick;
      logic security_loaded;
      logic [1:0] key_enable;
      logic [1:0] security;
      logic [2:0] index;
      logic irq_enable;
      logic complete;
      logic access_error;
      logic protection_error;
      logic [7:0] protection;
      logic [7:0] option;
      logic [7:0][15:0] command_object;
      logic [15:0] sequencer_word;
      logic [31:0] read_data;
      logic launch;
      logic irq;
      logic key_ok;
      logic secured;
   } state_type;

   state_type state;
   state_type next_state;

   // Lane mask for a word-relative access
   function automatic logic [3:0] lane_mask(input logic [1:0] low, input logic [1:0] size);
      logic [3:0] mask;
      mask = 4'h0;
      case (size)
         SIZE_BYTE: mask = 4'h1 << low;
         SIZE_HALF: mask = low[1] ? 4'hC : 4'h3;
         SIZE_WORD: mask = 4'hF;
         default: mask = 4'h0;
      endcase
      return mask;
   endfunction

   // Address hit for one byte register
   function automatic logic byte_hit(input logic [15:0] addr, input logic [3:0] lanes,
                                      input logic [15:0] target);
      return (addr[15:2] == target[15:2]) && lanes[target[1:0]];
   endfunction

   function automatic logic [7:0] lane_byte(input logic [31:0] data, input logic [1:0] lane);
      return data[8 * lane +: 8];
   endfunction

   logic [3:0] lanes;
   logic writable;
   logic [7:0] divider_data;
   logic [7:0] status_data;
   logic [7:0] status_read;
   logic [31:0] word_read;
   logic divider_hit;
   logic index_hit;
   logic config_hit;
   logic status_hit;
   logic protection_hit;
   logic option_hit;
   logic high_hit;
   logic low_hit;
   logic [7:0] index_data;
   logic [7:0] config_data;
   logic [7:0] protection_data;
   logic [7:0] option_data;
   logic [7:0] high_data;
   logic [7:0] low_data;

   always_comb begin
      lanes = lane_mask(address[1:0], access_size);
      // Per-register address decode
      divider_hit = byte_hit(address, lanes, ADDR_CLOCK_DIVIDER);
      index_hit = byte_hit(address, lanes, ADDR_COMMAND_INDEX);
      config_hit = byte_hit(address, lanes, ADDR_CONFIGURATION);
      status_hit = byte_hit(address, lanes, ADDR_STATUS);
      protection_hit = byte_hit(address, lanes, ADDR_PROTECTION);
      option_hit = byte_hit(address, lanes, ADDR_OPTION);
      high_hit = byte_hit(address, lanes, ADDR_COMMAND_HIGH);
      low_hit = byte_hit(address, lanes, ADDR_COMMAND_LOW);
      index_data = lane_byte(write_data, ADDR_COMMAND_INDEX[1:0]);
      config_data = lane_byte(write_data, ADDR_CONFIGURATION[1:0]);
      protection_data = lane_byte(write_data, ADDR_PROTECTION[1:0]);
      option_data = lane_byte(write_data, ADDR_OPTION[1:0]);
      high_data = lane_byte(write_data, ADDR_COMMAND_HIGH[1:0]);
      low_data = lane_byte(write_data, ADDR_COMMAND_LOW[1:0]);
      // Writes only while no command runs
      // busy write gate
      writable = write_strobe && state.complete;
      divider_data = lane_byte(write_data, ADDR_CLOCK_DIVIDER[1:0]);
      status_data = lane_byte(write_data, ADDR_STATUS[1:0]);
      status_read = {state.complete, 1'b0, state.access_error, state.protection_error,
                     ~state.complete, 1'b0, memory_status};
      word_read = 32'h0000_0000;
      case (address[15:2])
         ADDR_CLOCK_DIVIDER[15:2]: begin
            word_read = {8'h00, 5'h00, state.index,
                         state.key_enable, 4'h0, state.security,
                         state.loaded, state.lock, state.divider};
         end
         ADDR_CONFIGURATION[15:2]: begin
            word_read = {8'h00, status_read, 8'h00, state.irq_enable, 7'h00};
         end
         ADDR_PROTECTION[15:2]: begin
            word_read = {state.command_object[state.index][7:0],
                         state.command_object[state.index][15:8], 8'h00, state.protection};
         end
         ADDR_OPTION[15:2]: begin
            word_read = {24'h00_0000, state.option};
         end
         default: word_read = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_state = state;
      next_state.launch = 1'b0;
      next_state.read_data = 32'h0000_0000;
      if (read_strobe) begin
         for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
               next_state.read_data[8 * i +: 8] = word_read[8 * i +: 8];
            end
         end
      end
      if (!state.security_loaded) begin
         next_state.security_loaded = 1'b1;
         next_state.key_enable = security_byte[7:6];
         next_state.security = security_byte[1:0];
      end
      if (backdoor_unsecure) begin
         next_state.security = UNSECURED_CODE;
      end
      if (writable && divider_hit) begin
         next_state.loaded = 1'b1;
         if (background_debug_mode) begin
            next_state.divider = divider_data[5:0];
            next_state.lock = divider_data[DIVIDER_LOCK_BIT];
         end else if (!state.lock) begin
            next_state.divider = divider_data[5:0];
            next_state.lock = divider_data[DIVIDER_LOCK_BIT];
         end
      end
      if (writable && index_hit) begin
         next_state.index = index_data[2:0];
      end
      if (writable && config_hit) begin
         next_state.irq_enable = config_data[IRQ_ENABLE_BIT];
      end
      if (writable && protection_hit) begin
         next_state.protection = protection_data;
      end
      if (writable && option_hit) begin
         next_state.option = option_data;
      end
      if (writable && high_hit) begin
         next_state.command_object[state.index][15:8] = high_data;
      end
      if (writable && low_hit) begin
         next_state.command_object[state.index][7:0] = low_data;
      end
      if (writable && status_hit) begin
         if (status_data[ACCESS_ERROR_BIT]) begin
            next_state.access_error = 1'b0;
         end
         if (status_data[PROTECTION_ERROR_BIT]) begin
            next_state.protection_error = 1'b0;
         end
         if (status_data[COMPLETE_BIT] && !state.access_error && !state.protection_error) begin
            next_state.complete = 1'b0;
            next_state.launch = 1'b1;
         end
      end
      // Hardware set wins over clear
      if (set_access_error) begin
         next_state.access_error = 1'b1;
      end
      if (set_protection_violation) begin
         next_state.protection_error = 1'b1;
      end
      if (command_done) begin
         next_state.complete = 1'b1;
      end
      next_state.tick = 1'b0;
      if (state.loaded) begin
         if (state.tick_count >= state.divider) begin
            next_state.tick_count = 6'h00;
            next_state.tick = 1'b1;
         end else begin
            next_state.tick_count = state.tick_count + 6'h01;
         end
      end
      next_state.sequencer_word = state.command_object[sequencer_index];
      next_state.irq = state.irq_enable && state.complete;
      next_state.key_ok = state.key_enable == KEY_ENABLED_CODE;
      next_state.secured = state.security != UNSECURED_CODE;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
         state.complete <= STATUS_RESET[COMPLETE_BIT];
         state.secured <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign read_data = state.read_data;
   assign sequencer_word = state.sequencer_word;
   assign command_launch = state.launch;
   assign command_complete_irq = state.irq;
   assign time_base_tick = state.tick;
   assign divider_value_field = state.divider;
   assign backdoor_key_enabled = state.key_ok;
   assign part_secured = state.secured;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   a_busy_write_held: assert property (write_strobe && !state.complete |=> $stable(state.divider)
      && $stable(state.index) && $stable(state.irq_enable)) else $error("write taken while busy");

   a_loaded_flag_sticky: assert property (state.loaded |=> state.loaded)
      else $error("loaded flag dropped");

   a_loaded_on_write: assert property (writable && divider_hit |=> state.loaded)
      else $error("loaded flag not set");

   a_lock_blocks_user: assert property (state.lock && !background_debug_mode |=> $stable(state.divider)
      && state.lock) else $error("locked divider changed");

   a_irq_tracks_flag: assert property (state.irq_enable && state.complete |=> command_complete_irq)
      else $error("interrupt missing");

   a_irq_disabled: assert property (!state.irq_enable |=> !command_complete_irq)
      else $error("interrupt while disabled");

   a_unsecure_forced: assert property (backdoor_unsecure |=>
      state.security == UNSECURED_CODE ##1 !part_secured) else $error("security not forced");

   a_launch_refused: assert property (state.access_error && !set_access_error |=> !command_launch)
      else $error("launch with access error");

   a_launch_clears: assert property (command_launch |-> !state.complete || $past(command_done))
      else $error("launch left flag high");

   a_read_quiet: assert property (!$past(read_strobe) |-> read_data == 32'h0000_0000)
      else $error("read data outside slot");

   a_index_reserved: assert property (read_strobe && address[15:2] == ADDR_COMMAND_INDEX[15:2]
      |=> read_data[23:19] == 5'h00) else $error("reserved index bits set");

   a_lock_no_clear: assert property (state.lock && !(writable && divider_hit && background_debug_mode)
      |=> state.lock) else $error("lock bit cleared");

   a_divider_readback: assert property (read_strobe && divider_hit
      |=> read_data[7:0] == $past({state.loaded, state.lock, state.divider})) else $error("divider read wrong");

   a_security_read: assert property (read_strobe && byte_hit(address, lanes, ADDR_SECURITY)
      |=> read_data[15:8] == $past({state.key_enable, 4'h0, state.security})) else $error("security read wrong");

   a_security_fixed: assert property (state.security_loaded && !backdoor_unsecure
      |=> $stable(state.key_enable) && $stable(state.security)) else $error("security register changed");

   a_key_decode: assert property (state.security_loaded
      |=> backdoor_key_enabled == ($past(state.key_enable) == KEY_ENABLED_CODE)) else $error("key decode wrong");

   a_secure_decode: assert property (state.security_loaded
      |=> part_secured == ($past(state.security) != UNSECURED_CODE)) else $error("secure decode wrong");

   a_config_reserved: assert property (read_strobe && config_hit |=> read_data[6:0] == 7'h00)
      else $error("reserved config bits set");

   a_index_write: assert property (writable && index_hit |=> state.index == $past(index_data[2:0]))
      else $error("index not written");

   a_object_select: assert property (read_strobe && high_hit
      |=> read_data[23:16] == $past(state.command_object[state.index][15:8])) else $error("object read wrong");

   a_sequencer_word: assert property (reset_n
      |=> sequencer_word == $past(state.command_object[sequencer_index])) else $error("sequencer word wrong");

   a_busy_held: assert property (!state.complete && !command_done |=> !state.complete)
      else $error("complete flag rose early");

   a_done_sets: assert property (command_done |=> state.complete)
      else $error("complete flag not set");

   a_error_blocks: assert property (state.access_error || state.protection_error |=> !command_launch)
      else $error("launch while error set");

   a_error_clear: assert property (writable && status_hit && status_data[ACCESS_ERROR_BIT]
      && !set_access_error |=> !state.access_error) else $error("access error not cleared");

   a_error_zero_write: assert property (state.access_error
      && !(writable && status_hit && status_data[ACCESS_ERROR_BIT]) |=> state.access_error)
      else $error("access error lost");

   a_launch_on_write: assert property (writable && status_hit && status_data[COMPLETE_BIT]
      && !state.access_error && !state.protection_error |=> command_launch) else $error("launch missing");

   a_tick_idle: assert property (!state.loaded |=> !time_base_tick)
      else $error("tick before divider loaded");

   a_tick_spacing: assert property (time_base_tick && state.divider != 6'h00 |=> !time_base_tick)
      else $error("ticks too close");

   a_irq_off_busy: assert property (!state.complete |=> !command_complete_irq)
      else $error("interrupt while busy");

   a_storage_busy: assert property (!writable |=> $stable(state.protection)
      && $stable(state.option) && $stable(state.command_object)) else $error("storage changed while busy");

   a_config_write: assert property (writable && config_hit
      |=> state.irq_enable == $past(config_data[IRQ_ENABLE_BIT])) else $error("enable not written");

   a_half_lanes: assert property (read_strobe && access_size == SIZE_HALF && !address[1]
      |=> read_data[31:16] == 16'h0000) else $error("upper half not masked");

   a_byte_lanes: assert property (read_strobe && access_size == SIZE_BYTE && address[1:0] == 2'h0
      |=> read_data[31:8] == 24'h00_0000) else $error("byte lanes not masked");

   a_debug_write: assert property (writable && divider_hit && background_debug_mode
      |=> state.divider == $past(divider_data[5:0])) else $error("debug divider write lost");

   a_lock_set_once: assert property (writable && divider_hit && !state.lock && !background_debug_mode
      |=> state.lock == $past(divider_data[DIVIDER_LOCK_BIT])) else $error("lock not taken");

   a_status_read: assert property (read_strobe && status_hit
      |=> read_data[23] == $past(state.complete)) else $error("complete flag read wrong");

   a_option_write: assert property (writable && option_hit |=> state.option == $past(option_data))
      else $error("option not written");
endmodule

// *** flash_sequencer_model.sv ***
// Behavioural model of the flash command sequencer
// Assumes it shares the bus clock and reset of the register bank
`timescale 1ns/1ps
module flash_sequencer_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic command_launch,
   input wire logic [7:0] done_delay,
   output logic command_done
);
   logic busy;
   logic [7:0] count;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         count <= 8'h00;
         command_done <= 1'b0;
      end else begin
         command_done <= 1'b0;
         if (command_launch) begin
            busy <= 1'b1;
            count <= done_delay;
         end else if (busy && count == 8'h00) begin
            busy <= 1'b0;
            command_done <= 1'b1;
         end else if (busy) begin
            count <= count - 8'h01;
         end
      end
   end
endmodule

// *** flash_reg_bank_tb.sv ***
// Self-checking bench for the flash register bank
// Assumes the sequencer model answers launches on the bus clock
`timescale 1ns/1ps
module flash_reg_bank_tb;
   import flash_reg_pkg::*;
   logic clock = 1'b0, reset_n = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0;
   logic background_debug_mode = 1'b0, backdoor_unsecure = 1'b0, set_access_error = 1'b0;
   logic [15:0] address = 16'h0000;
   logic [1:0] access_size = 2'h0;
   logic [31:0] write_data = 32'h0, read_data, v;
   logic [7:0] security_byte = 8'hBE, done_delay = 8'h0A;
   logic [2:0] sequencer_index = 3'h0;
   logic [15:0] sequencer_word;
   logic [5:0] divider_value_field;
   logic command_done, command_launch, command_complete_irq, time_base_tick, backdoor_key_enabled, part_secured;
   int bad_count = 0, checked = 0, n;
   flash_reg_bank DUT (.clock(clock), .reset_n(reset_n), .address(address), .access_size(access_size),
      .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .background_debug_mode(background_debug_mode), .security_byte(security_byte),
      .backdoor_unsecure(backdoor_unsecure), .command_done(command_done), .set_access_error(set_access_error),
      .set_protection_violation(1'b0), .memory_status(2'h0), .sequencer_index(sequencer_index),
      .sequencer_word(sequencer_word), .command_launch(command_launch), .command_complete_irq(command_complete_irq),
      .time_base_tick(time_base_tick), .divider_value_field(divider_value_field),
      .backdoor_key_enabled(backdoor_key_enabled), .part_secured(part_secured));
   flash_sequencer_model partner (.clock(clock), .reset_n(reset_n), .command_launch(command_launch),
      .done_delay(done_delay), .command_done(command_done));
   initial begin
      forever #2.5 clock = ~clock;
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [1:0] s, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      access_size <= s;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [1:0] s, output logic [31:0] d);
      @(posedge clock);
      address <= a;
      access_size <= s;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1 d = read_data;
   endtask
   task automatic do_reset(input logic [7:0] sb);
      @(posedge clock);
      reset_n <= 1'b0;
      security_byte <= sb;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
   endtask
   task automatic reset_values;
      rd(ADDR_CLOCK_DIVIDER, SIZE_WORD, v);
      chk("bank word", v, 32'h00008200);
      rd(ADDR_CONFIGURATION, SIZE_WORD, v);
      chk("config word", v, 32'h00800000);
      chk("secured", {31'h0, part_secured}, 32'h0);
      chk("key enabled", {31'h0, backdoor_key_enabled}, 32'h1);
   endtask
   task automatic divider_lock;
      wr(ADDR_CLOCK_DIVIDER, SIZE_BYTE, 32'h05);
      rd(ADDR_CLOCK_DIVIDER, SIZE_BYTE, v);
      chk("divider first", v, 32'h85);
      wr(ADDR_CLOCK_DIVIDER, SIZE_BYTE, 32'h47);
      wr(ADDR_CLOCK_DIVIDER, SIZE_BYTE, 32'h03);
      rd(ADDR_CLOCK_DIVIDER, SIZE_BYTE, v);
      chk("divider locked", v, 32'hC7);
      background_debug_mode <= 1'b1;
      wr(ADDR_CLOCK_DIVIDER, SIZE_BYTE, 32'h09);
      background_debug_mode <= 1'b0;
      rd(ADDR_CLOCK_DIVIDER, SIZE_BYTE, v);
      chk("divider debug", v, 32'h89);
      n = 0;
      repeat (100) begin
         @(posedge clock);
         #1 if (time_base_tick === 1'b1) n++;
      end
      chk("tick count", n, 32'd10);
   endtask
   task automatic secure_reset;
      wr(ADDR_CLOCK_DIVIDER, SIZE_BYTE, 32'h40);
      do_reset(8'h41);
      wr(ADDR_CLOCK_DIVIDER, SIZE_BYTE, 32'h02);
      rd(ADDR_CLOCK_DIVIDER, SIZE_BYTE, v);
      chk("divider unlocked", v, 32'h82);
      chk("secured", {30'h0, part_secured, backdoor_key_enabled}, 32'h2);
      backdoor_unsecure <= 1'b1;
      @(posedge clock);
      backdoor_unsecure <= 1'b0;
      rd(ADDR_SECURITY, SIZE_BYTE, v);
      chk("security forced", v, 32'h4200);
      chk("unsecured", {31'h0, part_secured}, 32'h0);
   endtask
   task automatic launch;
      wr(ADDR_CONFIGURATION, SIZE_BYTE, 32'hFF);
      rd(ADDR_CONFIGURATION, SIZE_BYTE, v);
      chk("config", v, 32'h80);
      wr(ADDR_STATUS, SIZE_BYTE, 32'h00800000);
      #1 chk("launch", {31'h0, command_launch}, 32'h1);
      wr(ADDR_COMMAND_INDEX, SIZE_BYTE, 32'h00030000);
      rd(ADDR_STATUS, SIZE_BYTE, v);
      chk("status busy", v | {31'h0, command_complete_irq}, 32'h00080000);
      repeat (20) @(posedge clock);
      rd(ADDR_COMMAND_INDEX, SIZE_WORD, v);
      chk("index kept", v, 32'h00004282);
      chk("irq", {31'h0, command_complete_irq}, 32'h1);
      set_access_error <= 1'b1;
      @(posedge clock);
      set_access_error <= 1'b0;
      wr(ADDR_STATUS, SIZE_BYTE, 32'h00800000);
      rd(ADDR_STATUS, SIZE_BYTE, v);
      chk("launch refused", v, 32'h00A00000);
      done_delay <= 8'h00;
      wr(ADDR_STATUS, SIZE_BYTE, 32'h00200000);
      wr(ADDR_STATUS, SIZE_BYTE, 32'h00800000);
      repeat (4) @(posedge clock);
      rd(ADDR_STATUS, SIZE_BYTE, v);
      chk("quick done", v, 32'h00800000);
   endtask
   task automatic command_object;
      wr(ADDR_COMMAND_INDEX, SIZE_BYTE, 32'h00FB0000);
      rd(ADDR_COMMAND_INDEX, SIZE_BYTE, v);
      chk("index", v, 32'h00030000);
      wr(ADDR_COMMAND_HIGH, SIZE_BYTE, 32'h00AB0000);
      wr(ADDR_COMMAND_LOW, SIZE_BYTE, 32'hCD000000);
      rd(ADDR_COMMAND_HIGH, SIZE_HALF, v);
      chk("object half", v, 32'hCDAB0000);
      sequencer_index <= 3'h3;
      wr(ADDR_COMMAND_INDEX, SIZE_BYTE, 32'h00010000);
      wr(ADDR_PROTECTION, SIZE_WORD, 32'h12340000);
      rd(ADDR_PROTECTION, SIZE_WORD, v);
      chk("object word", v, 32'h12340000);
      chk("sequencer word", {16'h0, sequencer_word}, 32'hABCD);
      rd(16'h3030, SIZE_BYTE, v);
      chk("unmapped", v, 32'h0);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      close_out();
   end
   initial begin
      do_reset(8'hBE);
      reset_values();
      divider_lock();
      secure_reset();
      launch();
      command_object();
      close_out();
   end
endmodule
